// >>> hw/ucr_regs.svh
// register offsets, field positions, mode codes and packet limits of the responder
`ifndef UCR_REGS_SVH
`define UCR_REGS_SVH
// word offsets on the bus
`define UCR_OFF_MODE 8'h00
`define UCR_OFF_COUNT 8'h04
`define UCR_OFF_DATA 8'h20
`define UCR_DATA_MASK 8'he0
// mode register fields
`define UCR_MODE_LSB 0
`define UCR_FLAG_A 4
`define UCR_FLAG_O 5
`define UCR_FLAG_I 6
`define UCR_FLAG_S 7
// count register fields
`define UCR_CNT_LSB 0
`define UCR_DVAL_BIT 6
`define UCR_TOG_BIT 7
// flag masks in set order {s, i, o, a}
`define UCR_SET_S 4'h8
`define UCR_SET_I 4'h4
`define UCR_SET_O 4'h2
`define UCR_SET_A 4'h1
// endpoint mode codes
`define UCR_MODE_DISABLE 4'h0
`define UCR_MODE_NAK 4'h1
`define UCR_MODE_STATOUT 4'h2
`define UCR_MODE_STALL 4'h3
`define UCR_MODE_ACKOUT 4'hb
`define UCR_MODE_ACKIN 4'hf
// packet limits
`define UCR_MAX_RX 4'ha
`define UCR_STATUS_CNT 4'h2
`define UCR_ZERO_WORD 32'h0000_0000
`endif

// >>> hw/ucr_pkg.sv
// types shared by the control endpoint responder
package ucr_pkg;
   typedef enum logic [1:0] {TK_SETUP, TK_IN, TK_OUT} ucr_tok_t;
   typedef enum logic [2:0] {EV_NONE, EV_SETUP_END, EV_OUT_END, EV_IN_TOK, EV_IN_ACK} ucr_evt_t;
   typedef enum logic [2:0] {RS_NONE, RS_ACK, RS_NAK, RS_STALL, RS_TX, RS_TX0} ucr_resp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_WAIT} ucr_state_t;
endpackage

// >>> hw/ucr_if.sv
// event and decision signals between the engine and its response table
interface ucr_if;
   import ucr_pkg::*;
   logic [3:0] mode;
   ucr_evt_t kind;
   logic [3:0] rx_count;
   logic rx_ok;
   logic rx_tog;
   ucr_resp_t resp;
   logic upd_mode;
   logic [3:0] new_mode;
   logic [3:0] set_flags;
   logic store;
   logic stat_fix;
   logic irq;
   modport engine (output mode, kind, rx_count, rx_ok, rx_tog,
      input resp, upd_mode, new_mode, set_flags, store, stat_fix, irq);
   modport table_side (input mode, kind, rx_count, rx_ok, rx_tog,
      output resp, upd_mode, new_mode, set_flags, store, stat_fix, irq);
endinterface

// >>> hw/ucr_decide.sv
// response table: maps mode and bus event to handshake and state updates
`include "ucr_regs.svh"
module ucr_decide (
   // decision port
   ucr_if.table_side d
);
   import ucr_pkg::*;
   logic ctl_mode;
   logic rx_good;
   logic status_good;
   // response per mode and event
   always_comb begin
      ctl_mode = (d.mode == `UCR_MODE_NAK) || (d.mode == `UCR_MODE_STATOUT) ||
         (d.mode == `UCR_MODE_STALL) || (d.mode == `UCR_MODE_ACKOUT) ||
         (d.mode == `UCR_MODE_ACKIN);
      rx_good = ctl_mode && (d.rx_count <= `UCR_MAX_RX) && d.rx_ok;
      status_good = (d.rx_count == `UCR_STATUS_CNT) && d.rx_tog;
      d.resp = RS_NONE;
      d.upd_mode = 1'b0;
      d.new_mode = d.mode;
      d.set_flags = 4'h0;
      d.store = 1'b0;
      d.stat_fix = 1'b0;
      d.irq = 1'b0;
      case (d.kind)
         EV_SETUP_END: begin
            if (rx_good) begin
               d.resp = RS_ACK;
               d.upd_mode = 1'b1;
               d.new_mode = `UCR_MODE_NAK;
               d.set_flags = `UCR_SET_S | `UCR_SET_A;
               d.store = 1'b1;
               d.irq = 1'b1;
            end
         end
         EV_OUT_END: begin
            if (rx_good) begin
               if (d.mode == `UCR_MODE_STALL) begin
                  d.resp = RS_STALL;
               end else if (d.mode == `UCR_MODE_NAK) begin
                  d.resp = RS_NAK;
               end else if (d.mode == `UCR_MODE_ACKOUT) begin
                  d.resp = RS_ACK;
                  d.upd_mode = 1'b1;
                  d.new_mode = `UCR_MODE_NAK;
                  d.set_flags = `UCR_SET_O | `UCR_SET_A;
                  d.store = 1'b1;
                  d.irq = 1'b1;
               end else if (status_good) begin
                  d.resp = RS_ACK;
                  d.upd_mode = 1'b1;
                  d.new_mode = (d.mode == `UCR_MODE_ACKIN) ? `UCR_MODE_STATOUT :
                     `UCR_MODE_STALL;
                  d.set_flags = `UCR_SET_O | `UCR_SET_A;
                  d.stat_fix = 1'b1;
                  d.irq = 1'b1;
               end else begin
                  d.resp = RS_STALL;
                  d.upd_mode = 1'b1;
                  d.new_mode = `UCR_MODE_STALL;
                  d.irq = 1'b1;
               end
            end
         end
         EV_IN_TOK: begin
            if (d.mode == `UCR_MODE_STALL) begin
               d.resp = RS_STALL;
            end else if (d.mode == `UCR_MODE_NAK) begin
               d.resp = RS_NAK;
            end else if (d.mode == `UCR_MODE_ACKIN) begin
               d.resp = RS_TX;
            end else if (d.mode == `UCR_MODE_ACKOUT) begin
               d.resp = RS_TX0;
            end else if (d.mode == `UCR_MODE_STATOUT) begin
               d.resp = RS_STALL;
               d.upd_mode = 1'b1;
               d.new_mode = `UCR_MODE_STALL;
               d.irq = 1'b1;
            end
         end
         EV_IN_ACK: begin
            if (d.mode == `UCR_MODE_ACKIN || d.mode == `UCR_MODE_ACKOUT) begin
               d.upd_mode = 1'b1;
               d.new_mode = (d.mode == `UCR_MODE_ACKIN) ? `UCR_MODE_NAK : `UCR_MODE_STALL;
               d.set_flags = `UCR_SET_I | `UCR_SET_A;
               d.irq = 1'b1;
            end
         end
         default: begin
            d.resp = RS_NONE;
         end
      endcase
   end
endmodule

// >>> hw/ucr_top.sv
// control endpoint responder: token handling, endpoint registers and bus slave
// Behaviour
// - mode 0000 ignores every token: no handshake, no state change
// - SETUP longer than ten bytes gets no handshake; buffer may hold junk
// - SETUP of ten bytes or fewer with bad data gets no handshake; buffer may hold junk
// - good SETUP: ACK, store data, toggle, count, valid, flags S A, mode 0001, interrupt
// - mode 0011 answers IN with STALL, nothing else changes
// - mode 0011 answers a good OUT with STALL, nothing else changes
// - OUT longer than ten bytes or with bad data gets no handshake
// - mode 0001 answers IN with NAK, nothing else changes
// - mode 0001 answers a good OUT with NAK, nothing else changes
// - mode 1111 sends the buffer on IN; host ACK sets I A, mode 0001, interrupt
// - mode 1111 OUT count not two: STALL, mode 0011, interrupt
// - mode 1111 two-byte OUT with toggle zero: STALL, mode 0011, interrupt
// - mode 1111 good status OUT: ACK, O A, mode 0010, toggle valid one, count 2
// - mode 0010 IN: STALL, mode 0011, interrupt
// - mode 0010 OUT with wrong count or toggle zero: STALL, mode 0011, interrupt
// - mode 0010 good status OUT: ACK, O A, mode 0011, toggle valid one, count 2
// - mode 1011 sends zero-length data on IN; host ACK sets I A, mode 0011
// - mode 1011 good OUT: ACK, store data, O A flags, mode 0001, interrupt
// - data reply to IN in mode 1111 sends exactly the programmed byte count
`include "ucr_regs.svh"
module ucr_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // tokens and received packets from the serial interface engine
   input wire logic tok_valid,
   input wire ucr_pkg::ucr_tok_t tok_kind,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic pkt_end,
   input wire logic [3:0] rx_count,
   input wire logic rx_ok,
   input wire logic received_toggle,
   // host handshake after a data reply
   input wire logic host_ack,
   input wire logic host_noack,
   // replies to the serial interface engine
   output logic hs_valid,
   output ucr_pkg::ucr_resp_t hs_code,
   output logic tx_start,
   output logic [3:0] tx_len,
   output logic tx_byte_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_byte_ready,
   // endpoint event
   output logic ep_irq
);
   import ucr_pkg::*;

   ucr_if dec ();

   ucr_decide u_decide (
      .d(dec.table_side)
   );

   // endpoint state
   ucr_state_t state_q, state_d;
   ucr_tok_t rtok_q, rtok_d;
   logic [3:0] mode_q, mode_d;
   logic [3:0] flags_q, flags_d;
   logic [3:0] count_q, count_d;
   logic tog_q, tog_d;
   logic dval_q, dval_d;
   logic [7:0] buf_q [8];
   logic [7:0] buf_d [8];
   logic [3:0] widx_q, widx_d;
   logic [2:0] tidx_q, tidx_d;
   logic [3:0] left_q, left_d;
   logic hs_valid_q, hs_valid_d;
   ucr_resp_t hs_code_q, hs_code_d;
   logic tx_start_q, tx_start_d;
   logic [3:0] tx_len_q, tx_len_d;
   logic tx_bv_q, tx_bv_d;
   logic [7:0] tx_byte_q, tx_byte_d;
   logic irq_q, irq_d;
   // bus state
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic hreadyout_q;
   logic addr_phase;
   logic fw_wr;
   logic rx_store;

   assign addr_phase = hsel && hready && htrans[1];
   assign fw_wr = wr_pend_q;

   // event presented to the response table
   always_comb begin
      dec.mode = mode_q;
      dec.rx_count = rx_count;
      dec.rx_ok = rx_ok;
      dec.rx_tog = received_toggle;
      dec.kind = EV_NONE;
      if (state_q == ST_IDLE && tok_valid && tok_kind == TK_IN) begin
         dec.kind = EV_IN_TOK;
      end else if (state_q == ST_RX && pkt_end) begin
         dec.kind = (rtok_q == TK_SETUP) ? EV_SETUP_END : EV_OUT_END;
      end else if (state_q == ST_WAIT && host_ack) begin
         dec.kind = EV_IN_ACK;
      end
   end

   // next state of the endpoint engine and its registers
   always_comb begin
      state_d = state_q;
      rtok_d = rtok_q;
      mode_d = mode_q;
      flags_d = flags_q;
      count_d = count_q;
      tog_d = tog_q;
      dval_d = dval_q;
      buf_d = buf_q;
      widx_d = widx_q;
      tidx_d = tidx_q;
      left_d = left_q;
      hs_valid_d = 1'b0;
      hs_code_d = hs_code_q;
      tx_start_d = 1'b0;
      tx_len_d = tx_len_q;
      tx_bv_d = tx_bv_q;
      tx_byte_d = tx_byte_q;
      irq_d = 1'b0;
      // firmware writes first so that hardware updates win
      if (fw_wr && wr_addr_q == `UCR_OFF_MODE) begin
         mode_d = hwdata[`UCR_MODE_LSB +: 4];
         flags_d = 4'h0;
      end else if (fw_wr && wr_addr_q == `UCR_OFF_COUNT) begin
         count_d = hwdata[`UCR_CNT_LSB +: 4];
         dval_d = hwdata[`UCR_DVAL_BIT];
         tog_d = hwdata[`UCR_TOG_BIT];
      end else if (fw_wr && (wr_addr_q & `UCR_DATA_MASK) == `UCR_OFF_DATA) begin
         buf_d[wr_addr_q[4:2]] = hwdata[7:0];
      end
      // buffer fills while a SETUP or an accepting OUT arrives
      rx_store = (rtok_q == TK_SETUP) || (mode_q == `UCR_MODE_ACKOUT);
      case (state_q)
         ST_IDLE: begin
            if (tok_valid && tok_kind == TK_IN) begin
               if (dec.resp == RS_TX || dec.resp == RS_TX0) begin
                  tx_start_d = 1'b1;
                  tx_len_d = (dec.resp == RS_TX) ? count_q : 4'h0;
                  left_d = tx_len_d;
                  if (tx_len_d == 4'h0) begin
                     state_d = ST_WAIT;
                  end else begin
                     tx_bv_d = 1'b1;
                     tx_byte_d = buf_q[0];
                     tidx_d = 3'h1;
                     state_d = ST_TX;
                  end
               end else if (dec.resp != RS_NONE) begin
                  hs_valid_d = 1'b1;
                  hs_code_d = dec.resp;
               end
            end else if (tok_valid && mode_q != `UCR_MODE_DISABLE) begin
               rtok_d = tok_kind;
               widx_d = 4'h0;
               state_d = ST_RX;
            end
         end
         ST_RX: begin
            if (rx_byte_valid && rx_store && !widx_q[3]) begin
               buf_d[widx_q[2:0]] = rx_byte;
               widx_d = widx_q + 4'h1;
            end
            if (pkt_end) begin
               state_d = ST_IDLE;
               if (dec.resp != RS_NONE) begin
                  hs_valid_d = 1'b1;
                  hs_code_d = dec.resp;
               end
            end
         end
         ST_TX: begin
            if (tx_bv_q && tx_byte_ready) begin
               if (left_q == 4'h1) begin
                  tx_bv_d = 1'b0;
                  state_d = ST_WAIT;
               end else begin
                  tx_byte_d = buf_q[tidx_q];
                  tidx_d = tidx_q + 3'h1;
                  left_d = left_q - 4'h1;
               end
            end
         end
         ST_WAIT: begin
            if (host_ack || host_noack) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // apply the table's updates
      if (dec.upd_mode) begin
         mode_d = dec.new_mode;
      end
      flags_d = flags_d | dec.set_flags;
      if (dec.store) begin
         count_d = rx_count;
         tog_d = received_toggle;
         dval_d = 1'b1;
      end
      if (dec.stat_fix) begin
         count_d = `UCR_STATUS_CNT;
         tog_d = 1'b1;
         dval_d = 1'b1;
      end
      irq_d = dec.irq;
   end

   // endpoint registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         rtok_q <= TK_SETUP;
         mode_q <= `UCR_MODE_DISABLE;
         flags_q <= 4'h0;
         count_q <= 4'h0;
         tog_q <= 1'b0;
         dval_q <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
         widx_q <= 4'h0;
         tidx_q <= 3'h0;
         left_q <= 4'h0;
         hs_valid_q <= 1'b0;
         hs_code_q <= RS_NONE;
         tx_start_q <= 1'b0;
         tx_len_q <= 4'h0;
         tx_bv_q <= 1'b0;
         tx_byte_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         rtok_q <= rtok_d;
         mode_q <= mode_d;
         flags_q <= flags_d;
         count_q <= count_d;
         tog_q <= tog_d;
         dval_q <= dval_d;
         buf_q <= buf_d;
         widx_q <= widx_d;
         tidx_q <= tidx_d;
         left_q <= left_d;
         hs_valid_q <= hs_valid_d;
         hs_code_q <= hs_code_d;
         tx_start_q <= tx_start_d;
         tx_len_q <= tx_len_d;
         tx_bv_q <= tx_bv_d;
         tx_byte_q <= tx_byte_d;
         irq_q <= irq_d;
      end
   end

   // bus slave: zero wait states, read data prepared in the address phase
   always_comb begin
      wr_pend_d = addr_phase && hwrite;
      wr_addr_d = addr_phase ? haddr[7:0] : wr_addr_q;
      hrdata_d = hrdata_q;
      if (addr_phase && !hwrite) begin
         if (haddr[31:8] != 24'h00_0000) begin
            hrdata_d = `UCR_ZERO_WORD;
         end else if (haddr[7:0] == `UCR_OFF_MODE) begin
            hrdata_d = {24'h00_0000, flags_q, mode_q};
         end else if (haddr[7:0] == `UCR_OFF_COUNT) begin
            hrdata_d = {24'h00_0000, tog_q, dval_q, 2'b00, count_q};
         end else if ((haddr[7:0] & `UCR_DATA_MASK) == `UCR_OFF_DATA && haddr[1:0] == 2'b00)
            begin
            hrdata_d = {24'h00_0000, buf_q[haddr[4:2]]};
         end else begin
            hrdata_d = `UCR_ZERO_WORD;
         end
      end
   end

   // bus registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= `UCR_ZERO_WORD;
         hreadyout_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
      end
   end

   // outputs straight from flip-flops, except hresp, which is tied low
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign hs_valid = hs_valid_q;
   assign hs_code = hs_code_q;
   assign tx_start = tx_start_q;
   assign tx_len = tx_len_q;
   assign tx_byte_valid = tx_bv_q;
   assign tx_byte = tx_byte_q;
   assign ep_irq = irq_q;
endmodule

// >>> tb/ucr_top_sva.sv
// concurrent checks on the control endpoint responder ports
module ucr_top_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   // token link
   input wire logic tok_valid,
   input wire ucr_pkg::ucr_tok_t tok_kind,
   input wire logic pkt_end,
   input wire logic [3:0] rx_count,
   input wire logic rx_ok,
   input wire logic host_noack,
   // replies
   input wire logic hs_valid,
   input wire ucr_pkg::ucr_resp_t hs_code,
   input wire logic tx_start,
   input wire logic [3:0] tx_len,
   input wire logic tx_byte_valid,
   input wire logic tx_byte_ready,
   input wire logic ep_irq
);
   import ucr_pkg::*;
   logic wrote_q, wrote_d;
   logic [3:0] cnt_q, cnt_d, len_q, len_d;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // firmware write seen, bytes taken in the running data reply
   always_comb begin
      wrote_d = wrote_q | (hsel & hready & htrans[1] & hwrite);
      len_d = tx_start ? tx_len : len_q;
      cnt_d = tx_start ? 4'h0 : cnt_q;
      if (tx_byte_valid && tx_byte_ready) begin
         cnt_d = cnt_d + 4'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wrote_q <= 1'b0;
         cnt_q <= 4'h0;
         len_q <= 4'h0;
      end else begin
         wrote_q <= wrote_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
      end
   end
   sequence s_bad_pkt;
      pkt_end && (!rx_ok || rx_count > 4'ha);
   endsequence
   sequence s_quiet;
      !hs_valid && !ep_irq;
   endsequence
   chk_before_fw: assert property (!wrote_q |-> !hs_valid && !tx_start && !ep_irq)
      else $error("reply while endpoint disabled");
   chk_bad_quiet: assert property (s_bad_pkt |=> s_quiet)
      else $error("reply to bad packet");
   chk_hs_cause: assert property (hs_valid |-> $past(pkt_end) ||
      $past(tok_valid && tok_kind == TK_IN))
      else $error("handshake without cause");
   chk_ack_irq: assert property (hs_valid && hs_code == RS_ACK |-> ep_irq)
      else $error("ack without interrupt");
   chk_nak_quiet: assert property (hs_valid && hs_code == RS_NAK |-> !ep_irq)
      else $error("nak with interrupt");
   chk_irq_pulse: assert property (ep_irq |=> !ep_irq)
      else $error("interrupt longer than one cycle");
   chk_noack_quiet: assert property (host_noack |=> !ep_irq [*2])
      else $error("interrupt after missing host ack");
   chk_tx_count: assert property ($fell(tx_byte_valid) |-> cnt_q == len_q)
      else $error("data reply byte count wrong");
   chk_tx_nohs: assert property (tx_start |-> !hs_valid)
      else $error("handshake with data reply");
endmodule
bind ucr_top ucr_top_sva i_ucr_top_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .tok_valid, .tok_kind, .pkt_end, .rx_count, .rx_ok, .host_noack, .hs_valid, .hs_code,
   .tx_start, .tx_len, .tx_byte_valid, .tx_byte_ready, .ep_irq);

// >>> tb/ucr_host_model.sv
// usb host model: sends tokens and packets, records the endpoint replies
module ucr_host_model (
   // clock and options
   input wire logic hclk,
   input wire logic slow,
   // token link
   output logic tok_valid = 1'b0,
   output ucr_pkg::ucr_tok_t tok_kind = ucr_pkg::TK_SETUP,
   output logic rx_byte_valid = 1'b0,
   output logic [7:0] rx_byte = 8'h00,
   output logic pkt_end = 1'b0,
   output logic [3:0] rx_count = 4'h0,
   output logic rx_ok = 1'b0,
   output logic received_toggle = 1'b0,
   output logic host_ack = 1'b0,
   output logic host_noack = 1'b0,
   output logic tx_byte_ready = 1'b1,
   // replies
   input wire logic hs_valid,
   input wire ucr_pkg::ucr_resp_t hs_code,
   input wire logic tx_start,
   input wire logic tx_byte_valid,
   input wire logic [7:0] tx_byte,
   input wire logic ep_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import ucr_pkg::*;
   ucr_resp_t last_hs = RS_NONE;
   logic [7:0] irq_cnt = 8'h00, tx_cnt = 8'h00, tx_first = 8'h00;
   logic tx_go = 1'b0;
   // record replies of the current transaction, pace the serializer
   always @(posedge hclk) begin
      if (tok_valid) begin
         last_hs <= RS_NONE;
         irq_cnt <= 8'h00;
         tx_cnt <= 8'h00;
         tx_go <= 1'b0;
      end else begin
         if (hs_valid) last_hs <= hs_code;
         if (ep_irq) irq_cnt <= irq_cnt + 8'h01;
         if (tx_start) tx_go <= 1'b1;
         if (tx_byte_valid && tx_byte_ready) begin
            tx_cnt <= tx_cnt + 8'h01;
            if (tx_cnt == 8'h00) tx_first <= tx_byte;
         end
      end
      tx_byte_ready <= slow ? ~tx_byte_ready : 1'b1;
   end
   // one token with its data packet or its data reply and host handshake
   task automatic xfer(input ucr_tok_t tk, input logic [3:0] n, input logic ok, tg, ak);
      int i;
      @(posedge hclk);
      tok_valid <= 1'b1;
      tok_kind <= tk;
      @(posedge hclk);
      tok_valid <= 1'b0;
      if (tk != TK_IN) begin
         for (i = 0; i < n; i++) begin
            rx_byte_valid <= 1'b1;
            rx_byte <= 8'(8'h30 + i);
            @(posedge hclk);
         end
         rx_byte_valid <= 1'b0;
         rx_byte <= ~rx_byte;
         pkt_end <= 1'b1;
         rx_count <= n;
         rx_ok <= ok;
         received_toggle <= tg;
         @(posedge hclk);
         pkt_end <= 1'b0;
         rx_ok <= ~ok;
         received_toggle <= ~tg;
      end else begin
         repeat (2) @(posedge hclk);
         for (i = 0; i < 40 && tx_byte_valid === 1'b1; i++) @(posedge hclk);
         if (tx_go) begin
            host_ack <= ak;
            host_noack <= ~ak;
            @(posedge hclk);
            host_ack <= 1'b0;
            host_noack <= 1'b0;
         end
      end
   endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the control endpoint responder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ucr_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, tok_valid, rx_byte_valid, pkt_end, rx_ok, received_toggle;
   logic host_ack, host_noack, hs_valid, tx_start, tx_byte_valid, tx_byte_ready, ep_irq;
   logic [7:0] rx_byte, tx_byte;
   logic [3:0] rx_count, tx_len;
   ucr_tok_t tok_kind;
   ucr_resp_t hs_code;
   int err_count = 0, check_count = 0, cyc = 0;
   always #4 hclk = ~hclk;
   ucr_top i_ucr_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tok_valid, .tok_kind, .rx_byte_valid,
      .rx_byte, .pkt_end, .rx_count, .rx_ok, .received_toggle, .host_ack, .host_noack,
      .hs_valid, .hs_code, .tx_start, .tx_len, .tx_byte_valid, .tx_byte, .tx_byte_ready,
      .ep_irq);
   ucr_host_model i_ucr_host_model (.hclk, .slow, .tok_valid, .tok_kind, .rx_byte_valid,
      .rx_byte, .pkt_end, .rx_count, .rx_ok, .received_toggle, .host_ack, .host_noack,
      .tx_byte_ready, .hs_valid, .hs_code, .tx_start, .tx_byte_valid, .tx_byte, .ep_irq);
   task automatic final_report();
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cut a hang short
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         $display("Error at %0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask
   // one ahb-lite single word transfer
   task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // optional mode write, one transaction, then handshake, interrupts and mode register
   task automatic run(input logic [7:0] mw, input ucr_tok_t tk, input logic [3:0] n,
      input logic ok, tg, ak, input ucr_resp_t ehs, input logic [7:0] eirq, emode);
      if (mw !== 8'hff) bus(1'b1, 32'h0000_0000, {24'h00_0000, mw}, rd);
      i_ucr_host_model.xfer(tk, n, ok, tg, ak);
      repeat (3) @(posedge hclk);
      chk({29'h0, i_ucr_host_model.last_hs}, {29'h0, ehs});
      chk({24'h00_0000, i_ucr_host_model.irq_cnt}, {24'h00_0000, eirq});
      bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
      chk(rd, {24'h00_0000, emode});
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      run(8'hff, TK_SETUP, 4'h8, 1, 1, 0, RS_NONE, 8'h00, 8'h00);
      run(8'h01, TK_SETUP, 4'hb, 1, 1, 0, RS_NONE, 8'h00, 8'h01);
      run(8'hff, TK_SETUP, 4'h8, 0, 1, 0, RS_NONE, 8'h00, 8'h01);
      run(8'hff, TK_SETUP, 4'h8, 1, 1, 0, RS_ACK, 8'h01, 8'h91);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd, 32'h0000_00c8);
      bus(1'b0, 32'h0000_0020, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0030);
      run(8'hff, TK_IN, 4'h0, 1, 0, 0, RS_NAK, 8'h00, 8'h91);
      run(8'hff, TK_OUT, 4'h2, 1, 1, 0, RS_NAK, 8'h00, 8'h91);
      run(8'hff, TK_OUT, 4'hb, 1, 1, 0, RS_NONE, 8'h00, 8'h91);
      run(8'hff, TK_OUT, 4'h4, 0, 1, 0, RS_NONE, 8'h00, 8'h91);
      run(8'h03, TK_IN, 4'h0, 1, 0, 0, RS_STALL, 8'h00, 8'h03);
      run(8'hff, TK_OUT, 4'h2, 1, 1, 0, RS_STALL, 8'h00, 8'h03);
      bus(1'b1, 32'h0000_0004, 32'h0000_0003, rd);
      bus(1'b1, 32'h0000_0020, 32'h0000_00a5, rd);
      slow <= 1'b1;
      run(8'h0f, TK_IN, 4'h0, 1, 0, 0, RS_NONE, 8'h00, 8'h0f);
      run(8'hff, TK_IN, 4'h0, 1, 0, 1, RS_NONE, 8'h01, 8'h51);
      chk({24'h00_0000, i_ucr_host_model.tx_cnt}, 32'h0000_0003);
      chk({24'h00_0000, i_ucr_host_model.tx_first}, 32'h0000_00a5);
      slow <= 1'b0;
      run(8'h0f, TK_OUT, 4'h3, 1, 1, 0, RS_STALL, 8'h01, 8'h03);
      run(8'h0f, TK_OUT, 4'h2, 1, 0, 0, RS_STALL, 8'h01, 8'h03);
      run(8'h0f, TK_OUT, 4'h2, 1, 1, 0, RS_ACK, 8'h01, 8'h32);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd, 32'h0000_00c2);
      run(8'hff, TK_OUT, 4'h2, 1, 1, 0, RS_ACK, 8'h01, 8'h33);
      run(8'h02, TK_IN, 4'h0, 1, 0, 0, RS_STALL, 8'h01, 8'h03);
      run(8'h02, TK_OUT, 4'h3, 1, 1, 0, RS_STALL, 8'h01, 8'h03);
      run(8'h02, TK_OUT, 4'h2, 1, 0, 0, RS_STALL, 8'h01, 8'h03);
      run(8'h0b, TK_IN, 4'h0, 1, 0, 1, RS_NONE, 8'h01, 8'h53);
      chk({24'h00_0000, i_ucr_host_model.tx_cnt}, 32'h0000_0000);
      run(8'h0b, TK_OUT, 4'h4, 1, 0, 0, RS_ACK, 8'h01, 8'h31);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0044);
      final_report();
   end
endmodule
